// ===== design/prw_map.vh
// Register offsets, field positions, reset values and timing constants of the reset and watchdog timers
`ifndef PRW_MAP_VH
`define PRW_MAP_VH
`define PRW_ADDR_W            12
`define PRW_WDMODE_ADDR       12'hf0f
`define PRW_STOPCTL_ADDR      12'hf10
`define PRW_STATUS_ADDR       12'hf11
`define PRW_WDMODE_RST        8'h0d
`define PRW_STOPCTL_RST       8'h20
`define PRW_STOPDLY_BIT       5
`define PRW_WD_STOP_BIT       3
`define PRW_WD_HALT_BIT       2
`define PRW_WIN_CYCLES        60
`define PRW_CPU_DIV           2
`define PRW_WIN_CLKS          (`PRW_WIN_CYCLES * `PRW_CPU_DIV)
`define PRW_RC_HZ             128000
`define PRW_POR_US            5000
`define PRW_T0_MS             5
`define PRW_T1_MS             10
`define PRW_T2_MS             20
`define PRW_T3_MS             80
`define PRW_T4_MS             320
`define PRW_T5_MS             1280
`define PRW_T6_MS             5120
`endif

// ===== design/prw_top.v
// Power-on reset delay timer and watchdog timer with time-windowed mode register
// Operation
// - Reset held by RC-clocked one-shot delay
// - Delay starts on power-up and brownout return
// - Delay also starts on watchdog time-out
// - Stop recovery delays only when stop-delay set
// - Watchdog is retriggerable one-shot resetting CPU
// - First instruction enables, later ones refresh
// - Watchdog counts on independent RC oscillator
// - Watchdog instruction updates zero, sign, overflow
// - Mode writes accepted only first 60 cycles
// - Mode register is write-only, reads return zero
// - Stop recovery keeps mode register contents
// - Non-stop time-out restores mode reset value
// - Bit 3 stop activity, bit 2 halt activity
// - Low select bits give 5/10/20/80 ms
// - Upper bits give 320/1280/5120 ms
// - Invalid upper bits fall back to low bits
// - Stop-mode time-out resets chip out of STOP
// - Watchdog disabled after its reset completes
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "prw_map.vh"
module prw_top #(
  parameter RC_DIV   = 977,
  parameter POR_TICKS = 640,
  parameter MS_TICKS  = 128
) (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire [11:0] addr,
  input  wire [7:0]  wdata,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [7:0]  rdata,
  input  wire        power_good,
  input  wire        stop_wake,
  input  wire        wd_instr,
  input  wire        cpu_halt,
  input  wire        cpu_stop,
  input  wire [7:0]  instr_result,
  output reg         chip_reset,
  output reg         stop_exit,
  output reg  [2:0]  flags_zsv,
  output reg         flags_we
);
  // RC oscillator modelled as a divided tick of sys_clk; RC_DIV defaults to 125MHz/128kHz
  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_DLY  = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;

  // Index 0 carries the supply level, index 1 the stop wake level
  reg  [1:0]  sync_a_r;
  reg  [1:0]  sync_b_r;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [9:0]  rc_cnt_r;
  reg         rc_tick_r;
  reg  [31:0] por_cnt_r;
  reg  [7:0]  wdmode_r;
  reg  [7:0]  stopctl_r;
  reg         wd_en_r;
  reg  [31:0] wd_cnt_r;
  reg  [31:0] wd_lim;
  reg  [7:0]  win_cnt_r;
  reg         win_open_r;
  reg         stop_rec_r;
  reg         wd_stop_r;
  reg         wd_fire;
  reg  [1:0]  last_cause_r;
  reg         wd_active;

  wire [1:0]  async_in;
  wire        pg_s;
  wire        sw_s;
  wire        fast_rec;
  wire        dly_rec;
  wire        mode_wr;
  wire [2:0]  up;
  wire [7:0]  status_word;

  // Time-out limits in RC ticks; one extra tick covers a partial first RC period
  localparam integer LIM_T0 = `PRW_T0_MS * MS_TICKS + 1;
  localparam integer LIM_T1 = `PRW_T1_MS * MS_TICKS + 1;
  localparam integer LIM_T2 = `PRW_T2_MS * MS_TICKS + 1;
  localparam integer LIM_T3 = `PRW_T3_MS * MS_TICKS + 1;
  localparam integer LIM_T4 = `PRW_T4_MS * MS_TICKS + 1;
  localparam integer LIM_T5 = `PRW_T5_MS * MS_TICKS + 1;
  localparam integer LIM_T6 = `PRW_T6_MS * MS_TICKS + 1;
  // Cause codes shown in the status register
  localparam [1:0] CAUSE_NONE    = 2'h0;
  localparam [1:0] CAUSE_STOP    = 2'h1;
  localparam [1:0] CAUSE_WD_RUN  = 2'h2;
  localparam [1:0] CAUSE_WD_STOP = 2'h3;

  assign async_in    = {stop_wake, power_good};
  assign pg_s        = sync_b_r[0];
  assign sw_s        = sync_b_r[1];
  assign up          = wdmode_r[6:4];
  // Stop recovery with the delay bit clear skips the delay
  assign fast_rec    = (state_r == ST_RUN) && cpu_stop && sw_s && !stopctl_r[`PRW_STOPDLY_BIT] && !wd_fire;
  assign dly_rec     = (state_r == ST_RUN) && (state_nxt == ST_DLY) && !wd_fire;
  assign mode_wr     = wr_stb && (addr == `PRW_WDMODE_ADDR) && win_open_r && (state_r == ST_RUN);
  assign status_word = {stop_rec_r, wd_stop_r, last_cause_r, win_open_r, wd_en_r, state_r};

  // Halted or stopped CPU only lets the counter run when the matching mode bit allows it
  always @* begin
    if (!wd_en_r) begin
      wd_active = 1'b0;
    end else if (cpu_stop) begin
      wd_active = wdmode_r[`PRW_WD_STOP_BIT];
    end else if (cpu_halt) begin
      wd_active = wdmode_r[`PRW_WD_HALT_BIT];
    end else begin
      wd_active = 1'b1;
    end
  end

  // Time-out select; invalid upper patterns fall back to the low select bits
  always @* begin
    case (up)
      3'h1: begin
        wd_lim = LIM_T4;
      end
      3'h2: begin
        wd_lim = LIM_T5;
      end
      3'h4: begin
        wd_lim = LIM_T6;
      end
      default: begin
        case (wdmode_r[1:0])
          2'h0:    wd_lim = LIM_T0;
          2'h1:    wd_lim = LIM_T1;
          2'h2:    wd_lim = LIM_T2;
          default: wd_lim = LIM_T3;
        endcase
      end
    endcase
  end

  // Terminal count is taken on the RC tick that would reach the limit
  always @* begin
    wd_fire = 1'b0;
    if ((state_r == ST_RUN) && wd_active && rc_tick_r && (wd_cnt_r + 32'h1 >= wd_lim)) begin
      wd_fire = 1'b1;
    end
  end

  // Reset sequencing: held while the supply is low, then the one-shot delay
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD: begin
        if (pg_s) begin
          state_nxt = ST_DLY;
        end
      end
      ST_DLY: begin
        if (rc_tick_r && (por_cnt_r + 32'h1 >= POR_TICKS)) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!pg_s) begin
          state_nxt = ST_HOLD;
        end else if (wd_fire) begin
          state_nxt = ST_DLY;
        end else if (cpu_stop && sw_s && stopctl_r[`PRW_STOPDLY_BIT]) begin
          state_nxt = ST_DLY;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
  end

  // Two flip-flops per asynchronous level; only the second stage feeds logic
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          sync_a_r[gi] <= 1'b0;
          sync_b_r[gi] <= 1'b0;
        end else begin
          sync_a_r[gi] <= async_in[gi];
          sync_b_r[gi] <= sync_a_r[gi];
        end
      end
    end
  endgenerate

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // RC oscillator tick; runs free so both timers share one time base
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rc_cnt_r  <= 10'h0;
      rc_tick_r <= 1'b0;
    end else if (rc_cnt_r == RC_DIV - 1) begin
      rc_cnt_r  <= 10'h0;
      rc_tick_r <= 1'b1;
    end else begin
      rc_cnt_r  <= rc_cnt_r + 10'h1;
      rc_tick_r <= 1'b0;
    end
  end

  // Delay count only advances while the delay state holds the reset
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      por_cnt_r <= 32'h0;
    end else if (state_r != ST_DLY) begin
      por_cnt_r <= 32'h0;
    end else if (rc_tick_r) begin
      por_cnt_r <= por_cnt_r + 32'h1;
    end
  end

  // Power loss and a time-out outside STOP restore the mode; stop recovery keeps it
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wdmode_r <= `PRW_WDMODE_RST;
    end else if (state_r == ST_HOLD) begin
      wdmode_r <= `PRW_WDMODE_RST;
    end else if (wd_fire && !cpu_stop) begin
      wdmode_r <= `PRW_WDMODE_RST;
    end else if (mode_wr) begin
      wdmode_r <= {1'b0, wdata[6:0]};
    end
  end

  // Power loss also restores the stop delay bit
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stopctl_r <= `PRW_STOPCTL_RST;
    end else if (state_r == ST_HOLD) begin
      stopctl_r <= `PRW_STOPCTL_RST;
    end else if (wr_stb && (addr == `PRW_STOPCTL_ADDR)) begin
      stopctl_r <= wdata;
    end
  end

  // Any reset leaves the watchdog disabled until the next refresh instruction
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wd_en_r <= 1'b0;
    end else if (state_r != ST_RUN) begin
      wd_en_r <= 1'b0;
    end else if (wd_instr) begin
      wd_en_r <= 1'b1;
    end
  end

  // A refresh restarts the count from zero
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wd_cnt_r <= 32'h0;
    end else if ((state_r != ST_RUN) || wd_instr) begin
      wd_cnt_r <= 32'h0;
    end else if (wd_active && rc_tick_r) begin
      wd_cnt_r <= wd_cnt_r + 32'h1;
    end
  end

  // Mode write window: restarted by every reset and by a fast stop recovery
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      win_open_r <= 1'b0;
    end else if ((state_r != ST_RUN) || fast_rec) begin
      win_open_r <= 1'b1;
    end else if (win_open_r && (win_cnt_r == `PRW_WIN_CLKS - 1)) begin
      win_open_r <= 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      win_cnt_r <= 8'h0;
    end else if ((state_r != ST_RUN) || fast_rec) begin
      win_cnt_r <= 8'h0;
    end else if (win_open_r && (win_cnt_r != `PRW_WIN_CLKS - 1)) begin
      win_cnt_r <= win_cnt_r + 8'h1;
    end
  end

  // Remembers whether the last time-out happened in STOP
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wd_stop_r <= 1'b0;
    end else if (wd_fire) begin
      wd_stop_r <= cpu_stop;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stop_rec_r <= 1'b0;
    end else if (dly_rec) begin
      stop_rec_r <= 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      last_cause_r <= CAUSE_NONE;
    end else if (wd_fire) begin
      last_cause_r <= cpu_stop ? CAUSE_WD_STOP : CAUSE_WD_RUN;
    end else if (dly_rec || fast_rec) begin
      last_cause_r <= CAUSE_STOP;
    end
  end

  // Read data stand for one cycle only and return to zero after
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h0;
    end else if (rd_stb) begin
      case (addr)
        `PRW_WDMODE_ADDR:  rdata <= 8'h0;
        `PRW_STOPCTL_ADDR: rdata <= stopctl_r;
        `PRW_STATUS_ADDR:  rdata <= status_word;
        default:           rdata <= 8'h0;
      endcase
    end else begin
      rdata <= 8'h0;
    end
  end

  // Registered from the next state so the reset drops with the state change
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chip_reset <= 1'b1;
    end else begin
      chip_reset <= (state_nxt != ST_RUN);
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stop_exit <= 1'b0;
    end else begin
      stop_exit <= (state_r == ST_RUN) && (state_nxt == ST_DLY) && cpu_stop;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags_we <= 1'b0;
    end else begin
      flags_we <= wd_instr && (state_r == ST_RUN);
    end
  end

  // Overflow is always cleared by the refresh instruction
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags_zsv <= 3'h0;
    end else if (wd_instr && (state_r == ST_RUN)) begin
      flags_zsv <= {instr_result == 8'h0, instr_result[7], 1'b0};
    end
  end
endmodule // prw_top

// ===== sim/prw_checker.sv
// Port-level assertions for the reset delay timer and watchdog
`timescale 1ns/10ps
module prw_checker (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [11:0] addr,
  input wire logic        rd_stb,
  input wire logic        wd_instr,
  input wire logic [7:0]  instr_result,
  input wire logic [7:0]  rdata,
  input wire logic        chip_reset,
  input wire logic        stop_exit,
  input wire logic [2:0]  flags_zsv,
  input wire logic        flags_we
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_wd_take;
    wd_instr && !chip_reset;
  endsequence
  a_flags_pulse: assert property (s_wd_take |=> flags_we) else $error("flag write missing");
  a_flags_zero: assert property (s_wd_take |=> flags_zsv[2] == ($past(instr_result) == 8'h00))
    else $error("zero flag wrong");
  a_flags_sign: assert property (s_wd_take |=> flags_zsv[1:0] == {$past(instr_result[7]), 1'b0})
    else $error("sign or overflow flag wrong");
  a_flags_idle: assert property (!wd_instr |=> !flags_we) else $error("spurious flag write");
  a_rst_ignores: assert property (chip_reset && wd_instr |=> !flags_we) else $error("instr taken in reset");
  a_mode_unread: assert property (rd_stb && addr == 12'hf0f |=> rdata == 8'h00) else $error("mode readable");
  a_rdata_quiet: assert property (!rd_stb |=> rdata == 8'h00) else $error("read data outside slot");
  a_stop_pulse: assert property (stop_exit |=> !stop_exit) else $error("stop exit too long");
  a_exit_resets: assert property (stop_exit |-> chip_reset) else $error("stop exit without reset");
  // A reset released too early would let the CPU run on an unsettled clock
  a_rst_hold: assert property ($rose(chip_reset) |-> chip_reset [*4]) else $error("reset pulse short");
endmodule // prw_checker
bind prw_top prw_checker prw_checker_i (.*);

// ===== sim/prw_top_tb.sv
// Self-checking bench for the reset delay timer and watchdog
`timescale 1ns/10ps
module prw_top_tb;
  logic       sys_clk, rstn, wr_stb, rd_stb, power_good, stop_wake, wd_instr, cpu_halt, cpu_stop;
  logic       chip_reset, stop_exit, flags_we, seen_exit;
  logic [11:0] addr;
  logic [7:0] wdata, instr_result, rdata, lf;
  logic [2:0] flags_zsv;
  int         n_fail, n_checks, n;
  logic [7:0] modes [$] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20, 8'h40, 8'h30, 8'h70, 8'h03};
  prw_top #(.RC_DIV(2), .POR_TICKS(4), .MS_TICKS(1)) prw_top_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Minimum period in sys_clk cycles: ms x MS_TICKS x RC_DIV
  function automatic int mc(input logic [7:0] m);
    case (m[6:4])
      3'b001: return 320 * 2;
      3'b010: return 1280 * 2;
      3'b100: return 5120 * 2;
      default: return (m[1:0] == 2'b00 ? 5 : m[1:0] == 2'b01 ? 10 : m[1:0] == 2'b10 ? 20 : 80) * 2;
    endcase
  endfunction
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkn(input int g, input int lo, input int hi);
    n_checks++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("[FAIL] %0t period %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic wait_rst(input logic v, input int b);
    n = 0;
    while (chip_reset !== v && n < b) begin
      @(negedge sys_clk);
      seen_exit |= stop_exit;
      n++;
    end
    if (chip_reset !== v) begin
      n_fail++;
      $display("[FAIL] %0t reset wait ran out", $time);
      give_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= w;
    rd_stb <= !w;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    if (!w) chk8(rdata, d);
  endtask
  task automatic wd;
    lf = nx(lf);
    @(posedge sys_clk);
    instr_result <= lf;
    wd_instr <= 1'b1;
    @(posedge sys_clk);
    wd_instr <= 1'b0;
    @(negedge sys_clk);
    chk8({4'h0, flags_we, flags_zsv}, {4'h0, 1'b1, lf == 8'h00, lf[7], 1'b0});
  endtask
  // Allows for sync stages and RC phase above the minimum
  task automatic tmo(input logic [7:0] m);
    wd();
    wait_rst(1'b1, mc(m) + 20);
    chkn(n, mc(m) - 2, mc(m) + 10);
    wait_rst(1'b0, 100);
  endtask
  task automatic stp(input logic s, input logic w);
    @(posedge sys_clk);
    cpu_stop <= s;
    stop_wake <= w;
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge sys_clk);
    chk8({7'h0, chip_reset}, 8'h00);
  endtask
  initial begin
    {rstn, wr_stb, rd_stb, wd_instr, cpu_halt, cpu_stop, stop_wake, seen_exit} = '0;
    {addr, wdata, instr_result, n_fail, n_checks} = '0;
    power_good = 1'b1;
    lf = 8'h1b;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    chk8({7'h0, chip_reset}, 8'h01);
    wait_rst(1'b0, 200);
    bus(1'b0, 12'hf10, 8'h20);
    bus(1'b0, 12'hf0f, 8'h00);
    bus(1'b0, 12'h123, 8'h00);
    idle(40);
    foreach (modes[i]) begin
      bus(1'b1, 12'hf0f, modes[i]);
      tmo(modes[i]);
      idle(30);
    end
    idle(130);
    bus(1'b1, 12'hf0f, 8'h03);
    tmo(8'h0d);
    bus(1'b1, 12'hf0f, 8'h01);
    wd();
    @(posedge sys_clk);
    cpu_halt <= 1'b1;
    idle(80);
    @(posedge sys_clk);
    cpu_halt <= 1'b0;
    wait_rst(1'b1, 40);
    wait_rst(1'b0, 100);
    repeat (6) begin
      wd();
      idle(4);
    end
    wait_rst(1'b1, 30);
    wait_rst(1'b0, 100);
    bus(1'b1, 12'hf0f, 8'h0a);
    wd();
    stp(1'b1, 1'b0);
    wait_rst(1'b1, 60);
    stp(1'b0, 1'b0);
    wait_rst(1'b0, 100);
    chk8({7'h0, seen_exit}, 8'h01);
    tmo(8'h0a);
    bus(1'b1, 12'hf10, 8'h00);
    @(posedge sys_clk);
    power_good <= 1'b0;
    wait_rst(1'b1, 10);
    @(posedge sys_clk);
    power_good <= 1'b1;
    wait_rst(1'b0, 100);
    bus(1'b0, 12'hf10, 8'h20);
    stp(1'b1, 1'b1);
    wait_rst(1'b1, 10);
    stp(1'b0, 1'b0);
    wait_rst(1'b0, 100);
    idle(130);
    bus(1'b1, 12'hf10, 8'h00);
    stp(1'b1, 1'b1);
    idle(8);
    stp(1'b0, 1'b0);
    bus(1'b1, 12'hf0f, 8'h02);
    tmo(8'h02);
    give_verdict();
  end
endmodule // prw_top_tb
